// >>> design/fsw_freq_watchdog.sv
`timescale 1ns/1ps
`default_nettype none
module fsw_freq_watchdog #(
   parameter int unsigned TICK_SHORT_CYC = fsw_pkg::TICK_SHORT_CYC,
   parameter int unsigned TICK_LONG_CYC  = fsw_pkg::TICK_LONG_CYC,
   parameter int unsigned RST_PULSE_CYC  = fsw_pkg::RST_PULSE_CYC
) (
   // clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        rst_n_i,
   // ahb-lite slave
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic [31:0] hwdata_i,
   input  wire logic        hready_i,
   output logic      [31:0] hrdata_o,
   output logic             hreadyout_o,
   output logic             hresp_o,
   // strap pins
   input  wire logic [4:0]  strap_freq_code_i,
   // synthesizer control
   output logic             cpu_ratio_mode_o,
   output logic      [4:0]  freq_code_o,
   output logic      [8:0]  cpu_mult_o,
   output logic      [7:0]  cpu_div_o,
   output logic             freq_load_o,
   output logic             recovery_active_o,
   // system
   output logic             sys_reset_o,
   output logic             irq_o
);
   // ==================================================================
   // state
   typedef struct packed {
      logic                            ap_valid;
      logic                            ap_write;
      logic [fsw_pkg::AW-1:0]          ap_addr;
      logic                            rd_pend;
      logic [31:0]                     rdata;
      logic                            prog_en;
      logic                            strap_override;
      logic                            recovery_source_select;
      logic                            watchdog_enable;
      logic                            watchdog_tick_select;
      logic                            reset_on_expiry_enable;
      logic                            reset_on_freq_change_enable;
      logic [fsw_pkg::CODE_W-1:0]      sw_code;
      logic [fsw_pkg::CODE_W-1:0]      strap_freq_code;
      logic                            strap_taken;
      logic [fsw_pkg::NUM_W-1:0]       cpu_numerator_value;
      logic [fsw_pkg::DEN_W-1:0]       cpu_denominator_value;
      logic [fsw_pkg::NUM_W-1:0]       recovery_numerator;
      logic [fsw_pkg::DEN_W-1:0]       recovery_denominator;
      logic [fsw_pkg::TMO_W-1:0]       watchdog_timeout_value;
      logic [fsw_pkg::EV_W-1:0]        status;
      logic [fsw_pkg::EV_W-1:0]        mask;
      fsw_pkg::fsw_wd_t                wd_state;
      logic [fsw_pkg::CNT_W-1:0]       wd_cnt;
      logic [fsw_pkg::PRE_W-1:0]       pre_cnt;
      logic                            recovery;
      logic                            reload;
      logic                            ratio_mode;
      logic [fsw_pkg::CODE_W-1:0]      code_out;
      logic [fsw_pkg::NUM_W:0]         mult;
      logic [fsw_pkg::NUM_W-1:0]       div;
      logic                            load;
      logic [fsw_pkg::RST_W-1:0]       rst_cnt;
      logic                            rst_out;
   } fsw_state_t;

   fsw_state_t q;
   fsw_state_t d;

   // ==================================================================
   // address decode, shared by reads and writes
   function automatic logic [fsw_pkg::NREG-1:0] dec(input logic [fsw_pkg::AW-1:0] a);
      dec = '0;
      case (a)
         fsw_pkg::OFS_CTRL:   dec[0] = 1'b1;
         fsw_pkg::OFS_CPU:    dec[1] = 1'b1;
         fsw_pkg::OFS_RECOV:  dec[2] = 1'b1;
         fsw_pkg::OFS_WDT:    dec[3] = 1'b1;
         fsw_pkg::OFS_STATUS: dec[4] = 1'b1;
         fsw_pkg::OFS_MASK:   dec[5] = 1'b1;
         fsw_pkg::OFS_ACTIVE: dec[6] = 1'b1;
         default:             dec    = '0;
      endcase
   endfunction

   logic [fsw_pkg::NREG-1:0]   sel;
   logic                       wr;
   logic [31:0]                rw;
   logic [fsw_pkg::CODE_W-1:0] grp_code;
   logic                       n_ratio;
   logic [fsw_pkg::CODE_W-1:0] n_code;
   logic [fsw_pkg::NUM_W-1:0]  n_num;
   logic [fsw_pkg::DEN_W-1:0]  n_den;
   logic [fsw_pkg::NUM_W:0]    n_mult;
   logic [fsw_pkg::NUM_W-1:0]  n_div;
   logic [fsw_pkg::PRE_W-1:0]  lim;
   logic [fsw_pkg::CNT_W-1:0]  wd_reload;
   logic                       tick;
   logic                       expire_ev;
   logic [fsw_pkg::EV_W-1:0]   ev_set;
   logic [fsw_pkg::EV_W-1:0]   ev_clr;
   logic                       rst_trig;

   always_comb begin
      d = q;
      // ==============================================================
      // bus slave: writes land in the data phase, reads take one wait
      // state so a read right behind a write sees the new value
      sel = dec(q.ap_addr);
      wr  = q.ap_valid & q.ap_write & hready_i;
      d.rd_pend = 1'b0;
      if (hready_i) begin
         d.ap_valid = hsel_i & htrans_i[1];
         d.ap_write = hwrite_i;
         d.ap_addr  = haddr_i[fsw_pkg::AW-1:0];
         d.rd_pend  = hsel_i & htrans_i[1] & ~hwrite_i;
      end
      rw = '0;
      if (sel[0]) begin
         rw[fsw_pkg::C_PROG]  = q.prog_en;
         rw[fsw_pkg::C_OVR]   = q.strap_override;
         rw[fsw_pkg::C_RSRC]  = q.recovery_source_select;
         rw[fsw_pkg::C_WDEN]  = q.watchdog_enable;
         rw[fsw_pkg::C_TICK]  = q.watchdog_tick_select;
         rw[fsw_pkg::C_RSTWD] = q.reset_on_expiry_enable;
         rw[fsw_pkg::C_RSTFC] = q.reset_on_freq_change_enable;
         rw[fsw_pkg::C_SW_LO +: fsw_pkg::CODE_W]  = q.sw_code;
         rw[fsw_pkg::C_STR_LO +: fsw_pkg::CODE_W] = q.strap_freq_code;
      end
      if (sel[1]) begin
         rw[fsw_pkg::R_N_LO +: fsw_pkg::NUM_W] = q.cpu_numerator_value;
         rw[fsw_pkg::R_M_LO +: fsw_pkg::DEN_W] = q.cpu_denominator_value;
      end
      if (sel[2]) begin
         rw[fsw_pkg::R_N_LO +: fsw_pkg::NUM_W] = q.recovery_numerator;
         rw[fsw_pkg::R_M_LO +: fsw_pkg::DEN_W] = q.recovery_denominator;
      end
      if (sel[3]) begin
         rw[fsw_pkg::TMO_W-1:0]                   = q.watchdog_timeout_value;
         rw[fsw_pkg::W_CNT_LO +: fsw_pkg::CNT_W] = q.wd_cnt;
         rw[fsw_pkg::W_ST_LO +: 2]                = q.wd_state;
      end
      if (sel[4]) rw[fsw_pkg::EV_W-1:0] = q.status;
      if (sel[5]) rw[fsw_pkg::EV_W-1:0] = q.mask;
      if (sel[6]) begin
         rw[fsw_pkg::A_DIV_LO +: fsw_pkg::NUM_W]   = q.div;
         rw[fsw_pkg::A_MUL_LO +: fsw_pkg::NUM_W+1] = q.mult;
         rw[fsw_pkg::A_COD_LO +: fsw_pkg::CODE_W]  = q.code_out;
         rw[fsw_pkg::A_RATIO]                      = q.ratio_mode;
         rw[fsw_pkg::A_REC]                        = q.recovery;
      end
      if (q.rd_pend) d.rdata = rw;

      // ==============================================================
      // register writes
      ev_clr   = '0;
      d.reload = 1'b0;
      if (wr && sel[0]) begin
         d.prog_en                     = hwdata_i[fsw_pkg::C_PROG];
         d.strap_override              = hwdata_i[fsw_pkg::C_OVR];
         d.recovery_source_select      = hwdata_i[fsw_pkg::C_RSRC];
         d.watchdog_enable             = hwdata_i[fsw_pkg::C_WDEN];
         d.watchdog_tick_select        = hwdata_i[fsw_pkg::C_TICK];
         d.reset_on_expiry_enable      = hwdata_i[fsw_pkg::C_RSTWD];
         d.reset_on_freq_change_enable = hwdata_i[fsw_pkg::C_RSTFC];
         d.sw_code = hwdata_i[fsw_pkg::C_SW_LO +: fsw_pkg::CODE_W];
      end
      if (wr && sel[1]) begin
         d.cpu_numerator_value   = hwdata_i[fsw_pkg::R_N_LO +: fsw_pkg::NUM_W];
         d.cpu_denominator_value = hwdata_i[fsw_pkg::R_M_LO +: fsw_pkg::DEN_W];
         // one word carries both fields, so no half-updated ratio is loaded
         d.reload = q.prog_en & ~q.recovery;
      end
      if (wr && sel[2]) begin
         d.recovery_numerator   = hwdata_i[fsw_pkg::R_N_LO +: fsw_pkg::NUM_W];
         d.recovery_denominator = hwdata_i[fsw_pkg::R_M_LO +: fsw_pkg::DEN_W];
         d.reload = q.recovery & q.recovery_source_select;
      end
      if (wr && sel[3]) d.watchdog_timeout_value = hwdata_i[fsw_pkg::TMO_W-1:0];
      if (wr && sel[4]) ev_clr = hwdata_i[fsw_pkg::EV_W-1:0];
      if (wr && sel[5]) d.mask = hwdata_i[fsw_pkg::EV_W-1:0];

      // straps are caught once, on the first clock after reset release
      if (!q.strap_taken) begin
         d.strap_freq_code = strap_freq_code_i;
         d.strap_taken     = 1'b1;
      end

      // ==============================================================
      // frequency selection
      grp_code = q.strap_override ? q.sw_code : q.strap_freq_code;
      n_ratio  = 1'b0;
      n_code   = grp_code;
      n_num    = '0;
      n_den    = '0;
      if (q.recovery) begin
         if (q.recovery_source_select) begin
            n_ratio = 1'b1;
            n_num   = q.recovery_numerator;
            n_den   = q.recovery_denominator;
         end else begin
            n_code = q.strap_freq_code;
         end
      end else if (q.prog_en) begin
         n_ratio = 1'b1;
         n_num   = q.cpu_numerator_value;
         n_den   = q.cpu_denominator_value;
      end
      // the synthesizer is handed the biased terms of gear*(n+3)/(m+3)
      n_mult = {1'b0, n_num} + {1'b0, fsw_pkg::RATIO_BIAS};
      n_div  = {1'b0, n_den} + fsw_pkg::RATIO_BIAS;
      d.ratio_mode = n_ratio;
      d.code_out   = n_code;
      d.mult       = n_mult;
      d.div        = n_div;
      d.load = q.reload | (n_ratio != q.ratio_mode) | (n_code != q.code_out)
             | (n_mult != q.mult) | (n_div != q.div);

      // ==============================================================
      // watchdog
      lim = q.watchdog_tick_select ? fsw_pkg::PRE_W'(TICK_LONG_CYC - 1)
                                   : fsw_pkg::PRE_W'(TICK_SHORT_CYC - 1);
      // a zero timeout counts the full 32 ticks, the top of the range
      wd_reload = (q.watchdog_timeout_value == '0) ? fsw_pkg::WD_FULL
                : {1'b0, q.watchdog_timeout_value};
      // a tick select change mid-count must not let the prescaler run past its limit
      tick      = (q.pre_cnt >= lim);
      expire_ev = 1'b0;
      unique case (q.wd_state)
         fsw_pkg::WD_IDLE: begin
            d.wd_cnt  = wd_reload;
            d.pre_cnt = '0;
            if (q.watchdog_enable && q.load) d.wd_state = fsw_pkg::WD_RUN;
         end
         fsw_pkg::WD_RUN: begin
            if (!q.watchdog_enable) begin
               d.wd_state = fsw_pkg::WD_IDLE;
            end else if (q.load) begin
               d.wd_cnt  = wd_reload;
               d.pre_cnt = '0;
            end else if (tick) begin
               d.pre_cnt = '0;
               if (q.wd_cnt == fsw_pkg::CNT_W'(1)) begin
                  expire_ev  = 1'b1;
                  d.recovery = 1'b1;
                  // load even if the recovery setting equals the current one
                  d.reload   = 1'b1;
                  d.wd_state = fsw_pkg::WD_EXPIRED;
               end else begin
                  d.wd_cnt = q.wd_cnt - fsw_pkg::CNT_W'(1);
               end
            end else begin
               d.pre_cnt = q.pre_cnt + fsw_pkg::PRE_W'(1);
            end
         end
         fsw_pkg::WD_EXPIRED: begin
            // recovery holds until software acknowledges the timeout
            if (!q.status[fsw_pkg::S_EXP]) begin
               d.recovery = 1'b0;
               d.wd_state = fsw_pkg::WD_IDLE;
            end
         end
         default: d.wd_state = fsw_pkg::WD_IDLE;
      endcase

      // ==============================================================
      // events: a set in the same cycle as its clear wins
      ev_set = '0;
      ev_set[fsw_pkg::S_EXP]  = expire_ev;
      ev_set[fsw_pkg::S_LOAD] = q.load;
      d.status = (q.status & ~ev_clr) | ev_set;

      // ==============================================================
      // system reset pulse
      rst_trig = (expire_ev && q.reset_on_expiry_enable)
               || (q.load && q.reset_on_freq_change_enable);
      if (rst_trig) begin
         d.rst_cnt = fsw_pkg::RST_W'(RST_PULSE_CYC);
      end else if (q.rst_cnt != '0) begin
         d.rst_cnt = q.rst_cnt - fsw_pkg::RST_W'(1);
      end
      d.rst_out = (d.rst_cnt != '0);
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         q          <= '0;
         q.wd_state <= fsw_pkg::WD_IDLE;
      end else begin
         q <= d;
      end
   end

   assign hrdata_o          = q.rdata;
   assign hreadyout_o       = ~q.rd_pend;
   assign hresp_o           = 1'b0;
   assign cpu_ratio_mode_o  = q.ratio_mode;
   assign freq_code_o       = q.code_out;
   assign cpu_mult_o        = q.mult;
   assign cpu_div_o         = q.div;
   assign freq_load_o       = q.load;
   assign recovery_active_o = q.recovery;
   assign sys_reset_o       = q.rst_out;
   assign irq_o             = |(q.status & q.mask);

   // ==================================================================
   // checks
   logic [fsw_pkg::RST_W-1:0] hi_len_q;
   always_ff @(posedge sys_clk_i) begin
      // a retrigger restarts the pulse, so the measured width restarts too
      if (!rst_n_i)      hi_len_q <= '0;
      else if (rst_trig) hi_len_q <= '0;
      else               hi_len_q <= sys_reset_o ? hi_len_q + fsw_pkg::RST_W'(1) : '0;
   end

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);

   direct_mode_a: assert property (!q.recovery && !q.prog_en |=> !cpu_ratio_mode_o)
      else $error("direct mode left ratio mode set");
   override_code_a: assert property (!q.recovery && q.strap_override
      |=> freq_code_o == $past(q.sw_code))
      else $error("override did not select software code");
   strap_code_a: assert property (!q.recovery && !q.strap_override
      |=> freq_code_o == $past(q.strap_freq_code))
      else $error("strap code not selected");
   prog_ratio_a: assert property (!q.recovery && q.prog_en
      |=> cpu_ratio_mode_o && cpu_mult_o == {1'b0, $past(q.cpu_numerator_value)} + 9'h003
          && cpu_div_o == {1'b0, $past(q.cpu_denominator_value)} + 8'h03)
      else $error("programmed ratio terms wrong");
   cpu_wr_load_a: assert property (wr && sel[1] && q.prog_en && !q.recovery
      |-> ##2 freq_load_o)
      else $error("numerator write did not load");
   rec_src_a: assert property (q.recovery && !q.recovery_source_select
      |=> !cpu_ratio_mode_o && freq_code_o == $past(q.strap_freq_code))
      else $error("recovery from strap wrong");
   rec_ratio_a: assert property (q.recovery && q.recovery_source_select
      |=> cpu_ratio_mode_o && cpu_mult_o == {1'b0, $past(q.recovery_numerator)} + 9'h003)
      else $error("recovery ratio wrong");
   expiry_a: assert property (q.wd_state == fsw_pkg::WD_RUN && q.watchdog_enable && !q.load
      && tick && q.wd_cnt == 6'h01
      |=> q.status[fsw_pkg::S_EXP] && recovery_active_o)
      else $error("expiry not flagged");
   rec_switch_a: assert property ($rose(recovery_active_o) |-> ##[1:2] freq_load_o)
      else $error("no load on recovery switch");
   wd_off_a: assert property (!q.watchdog_enable && q.wd_state != fsw_pkg::WD_EXPIRED
      |=> q.wd_state == fsw_pkg::WD_IDLE)
      else $error("disabled watchdog still running");
   flag_clr_a: assert property (wr && sel[4] && hwdata_i[fsw_pkg::S_EXP] && !expire_ev
      |=> !q.status[fsw_pkg::S_EXP])
      else $error("expiry flag not cleared");
   flag_keep_a: assert property (wr && sel[4] && !hwdata_i[fsw_pkg::S_EXP]
      && q.status[fsw_pkg::S_EXP] |=> q.status[fsw_pkg::S_EXP])
      else $error("write zero cleared flag");
   tick_range_a: assert property (q.wd_state == fsw_pkg::WD_RUN
      && $stable(q.watchdog_tick_select) |-> q.pre_cnt <= lim)
      else $error("prescaler overran tick");
   rst_wd_a: assert property (expire_ev && q.reset_on_expiry_enable |=> sys_reset_o)
      else $error("no reset on expiry");
   rst_fc_a: assert property (freq_load_o && q.reset_on_freq_change_enable
      |=> sys_reset_o)
      else $error("no reset on change");
   rst_len_a: assert property ($fell(sys_reset_o)
      |-> hi_len_q == fsw_pkg::RST_W'(RST_PULSE_CYC))
      else $error("reset pulse width wrong");

   expiry_c: cover property (expire_ev);
   rst_c: cover property ($fell(sys_reset_o));
   rec_ratio_c: cover property (q.recovery && q.recovery_source_select && freq_load_o);
   rd_wait_c: cover property (!hreadyout_o ##1 hreadyout_o);
endmodule // fsw_freq_watchdog
`default_nettype wire

// >>> design/fsw_pkg.sv
`default_nettype none
package fsw_pkg;
   // ==================================================================
   // timing
   localparam int unsigned CLK_HZ         = 40_000_000;
   localparam int unsigned TICK_SHORT_MS  = 150;
   localparam real         TICK_LONG_S    = 2.5;
   localparam int unsigned TICK_SHORT_CYC = TICK_SHORT_MS * (CLK_HZ / 1000);
   localparam int unsigned TICK_LONG_CYC  = int'(TICK_LONG_S * real'(CLK_HZ));
   localparam int unsigned RST_PULSE_CYC  = 16;
   // ==================================================================
   // widths
   localparam int PRE_W  = 27;
   localparam int RST_W  = 16;
   localparam int CODE_W = 5;
   localparam int NUM_W  = 8;
   localparam int DEN_W  = 7;
   localparam int TMO_W  = 5;
   localparam int CNT_W  = 6;
   localparam int AW     = 8;
   localparam int EV_W   = 2;
   localparam int NREG   = 7;
   localparam logic [CNT_W-1:0] WD_FULL    = 6'h20;
   localparam logic [NUM_W-1:0] RATIO_BIAS = 8'h03;
   // ==================================================================
   // register map
   localparam logic [AW-1:0] OFS_CTRL   = 8'h00;
   localparam logic [AW-1:0] OFS_CPU    = 8'h04;
   localparam logic [AW-1:0] OFS_RECOV  = 8'h08;
   localparam logic [AW-1:0] OFS_WDT    = 8'h0c;
   localparam logic [AW-1:0] OFS_STATUS = 8'h10;
   localparam logic [AW-1:0] OFS_MASK   = 8'h14;
   localparam logic [AW-1:0] OFS_ACTIVE = 8'h18;
   // ctrl fields
   localparam int C_PROG   = 0;
   localparam int C_OVR    = 1;
   localparam int C_RSRC   = 2;
   localparam int C_WDEN   = 3;
   localparam int C_TICK   = 4;
   localparam int C_RSTWD  = 5;
   localparam int C_RSTFC  = 6;
   localparam int C_SW_LO  = 8;
   localparam int C_STR_LO = 16;
   // ratio, watchdog and active fields
   localparam int R_N_LO   = 0;
   localparam int R_M_LO   = 8;
   localparam int W_CNT_LO = 8;
   localparam int W_ST_LO  = 16;
   localparam int A_DIV_LO = 0;
   localparam int A_MUL_LO = 8;
   localparam int A_COD_LO = 20;
   localparam int A_RATIO  = 25;
   localparam int A_REC    = 26;
   // status and mask bits
   localparam int S_EXP  = 0;
   localparam int S_LOAD = 1;
   // ==================================================================
   typedef enum logic [1:0] {
      WD_IDLE    = 2'b00,
      WD_RUN     = 2'b01,
      WD_EXPIRED = 2'b10
   } fsw_wd_t;
endpackage
`default_nettype wire

// >>> sim/fsw_host.sv
`timescale 1ns/1ps
`default_nettype none
// ==================================================================
// ahb-lite master standing in for the configuration host
module fsw_host (
   // bus side
   input  wire logic        sys_clk_i,
   input  wire logic        hready_i,
   input  wire logic [31:0] hrdata_i,
   output logic             hsel_o,
   output logic      [31:0] haddr_o,
   output logic      [1:0]  htrans_o,
   output logic             hwrite_o,
   output logic      [2:0]  hsize_o,
   output logic      [31:0] hwdata_o
);
   initial begin
      hsel_o   = 1'b0;
      haddr_o  = 32'h0;
      htrans_o = 2'b00;
      hwrite_o = 1'b0;
      hsize_o  = 3'h2;
      hwdata_o = 32'h0;
   end
   // released write data is inverted so a stale value never looks valid
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      @(posedge sys_clk_i);
      hsel_o   <= 1'b1;
      htrans_o <= 2'b10;
      hwrite_o <= w;
      haddr_o  <= {24'h0, a};
      do @(posedge sys_clk_i); while (hready_i !== 1'b1);
      hsel_o   <= 1'b0;
      htrans_o <= 2'b00;
      hwdata_o <= d;
      do @(posedge sys_clk_i); while (hready_i !== 1'b1);
      q = hrdata_i;
      hwdata_o <= ~d;
   endtask
endmodule // fsw_host
`default_nettype wire

// >>> sim/tb_fsw_freq_watchdog.sv
`timescale 1ns/1ps
`default_nettype none
module tb_fsw_freq_watchdog;
   // ==================================================================
   // signals
   logic        sys_clk_i, rst_n_i, hsel_i, hwrite_i, hreadyout_o, hresp_o;
   logic        cpu_ratio_mode_o, freq_load_o, recovery_active_o, sys_reset_o, irq_o;
   logic [31:0] haddr_i, hwdata_i, hrdata_o, r;
   logic [1:0]  htrans_i;
   logic [2:0]  hsize_i;
   logic [4:0]  strap_freq_code_i, freq_code_o, sw;
   logic [8:0]  cpu_mult_o;
   logic [7:0]  cpu_div_o, n, rn;
   logic [6:0]  m, rm;
   int          k, e, cyc, mismatches, comparisons;
   // ==================================================================
   // short ticks keep the watchdog runs under twenty cycles
   fsw_freq_watchdog #(.TICK_SHORT_CYC(4), .TICK_LONG_CYC(8), .RST_PULSE_CYC(3))
   u_fsw_freq_watchdog (.sys_clk_i, .rst_n_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
      .hsize_i, .hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o,
      .strap_freq_code_i, .cpu_ratio_mode_o, .freq_code_o, .cpu_mult_o, .cpu_div_o,
      .freq_load_o, .recovery_active_o, .sys_reset_o, .irq_o);
   fsw_host u_fsw_host (.sys_clk_i, .hready_i(hreadyout_o), .hrdata_i(hrdata_o),
      .hsel_o(hsel_i), .haddr_o(haddr_i), .htrans_o(htrans_i), .hwrite_o(hwrite_i),
      .hsize_o(hsize_i), .hwdata_o(hwdata_i));
   // ==================================================================
   // tasks
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      u_fsw_host.xfer(1'b1, a, d, q);
   endtask
   task automatic step(input int c);
      repeat (c) @(posedge sys_clk_i);
      #1;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic results();
      if (mismatches == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      sys_clk_i = 1'b0;
      forever #12.5 sys_clk_i = ~sys_clk_i;
   end
   always @(posedge sys_clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         results();
      end
   end
   // ==================================================================
   // main sequence
   initial begin
      rst_n_i = 1'b0;
      void'($urandom(30188));
      strap_freq_code_i = 5'($urandom);
      sw = ~strap_freq_code_i;
      n = 8'h80 | 8'($urandom);
      m = 7'($urandom);
      rn = 8'h80 | 8'($urandom);
      rm = 7'($urandom);
      repeat (5) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      step(3);
      u_fsw_host.xfer(1'b0, fsw_pkg::OFS_CTRL, 32'h0, r);
      chk(r, {11'h0, strap_freq_code_i, 16'h0});
      #1;
      chk(32'({cpu_ratio_mode_o, freq_code_o}), 32'(strap_freq_code_i));
      wr(fsw_pkg::OFS_CTRL, {19'h0, sw, 8'h02});
      step(3);
      chk(32'({cpu_ratio_mode_o, freq_code_o}), 32'(sw));
      wr(fsw_pkg::OFS_CTRL, {19'h0, sw, 8'h01});
      wr(fsw_pkg::OFS_CPU, {17'h0, m, n});
      step(3);
      e = (int'(n) + 3) * 256 + int'(m) + 3;
      chk({8'h0, cpu_ratio_mode_o, freq_code_o, cpu_mult_o, cpu_div_o},
          {8'h1, strap_freq_code_i, 17'(e)});
      wr(fsw_pkg::OFS_CTRL, {19'h0, sw, 8'h03});
      step(3);
      chk(32'(freq_code_o), 32'(sw));
      // t selects tick, recovery source, reset enable and mask together
      for (int t = 0; t < 2; t++) begin
         wr(fsw_pkg::OFS_MASK, 32'(t));
         wr(fsw_pkg::OFS_RECOV, {17'h0, rm, rn});
         wr(fsw_pkg::OFS_WDT, 32'h2);
         wr(fsw_pkg::OFS_CTRL, {19'h0, sw, 2'b00, t[0], t[0], 1'b1, t[0], 2'b01});
         wr(fsw_pkg::OFS_CPU, {17'h0, m, n});
         for (k = 0; k < 9 && freq_load_o !== 1'b1; k++) step(1);
         for (k = 0; k < 99 && recovery_active_o !== 1'b1; k++) step(1);
         e = 2 * (4 + 4 * t) + 1;
         chk(32'(k >= e - 1 && k <= e + 2), 32'h1);
         chk(32'(irq_o), 32'(t));
         step(1);
         chk(32'(sys_reset_o), 32'(t));
         chk(32'({cpu_ratio_mode_o, freq_code_o}), 32'({t[0], strap_freq_code_i}));
         if (t == 1) begin
            chk(32'({cpu_mult_o, cpu_div_o}), 32'((int'(rn) + 3) * 256 + int'(rm) + 3));
            rm = rm + 7'h1;
            wr(fsw_pkg::OFS_RECOV, {17'h0, rm, rn});
            step(2);
            chk(32'(cpu_div_o), 32'(int'(rm) + 3));
         end
         wr(fsw_pkg::OFS_STATUS, 32'h0);
         u_fsw_host.xfer(1'b0, fsw_pkg::OFS_STATUS, 32'h0, r);
         chk(32'(r[0]), 32'h1);
         chk(32'(hresp_o), 32'h0);
         wr(fsw_pkg::OFS_CTRL, {19'h0, sw, 8'h01});
         wr(fsw_pkg::OFS_STATUS, 32'h1);
         step(2);
         chk(32'({recovery_active_o, irq_o}), 32'h0);
      end
      wr(fsw_pkg::OFS_CPU, {17'h0, m, n});
      step(40);
      chk(32'({recovery_active_o, sys_reset_o}), 32'h0);
      wr(fsw_pkg::OFS_CTRL, {19'h0, sw, 8'h41});
      wr(fsw_pkg::OFS_CPU, {17'h0, m, n});
      for (k = 0; k < 9 && sys_reset_o !== 1'b1; k++) step(1);
      for (k = 0; k < 9 && sys_reset_o === 1'b1; k++) step(1);
      chk(32'(k), 32'h3);
      results();
   end
endmodule // tb_fsw_freq_watchdog
`default_nettype wire
